/* File: core/pcb_cmd_bank.sv */
// Purpose: Command register bank with output enable and margin control
// Assumes: Protocol engine on LINK_CLK presents decoded accesses
// Notes: Accesses cross to SYS_CLK by a toggle handshake
// Behaviour
// - Overcurrent fault level at 46h, default by variant.
// - Fault action register at 47h, default 07h.
// - Overcurrent warning level at 4Ah, default by variant.
// - Overtemperature fault level at 4Fh, default 0096h.
// - Overtemperature warning level at 51h, default 007Dh.
// - Rise time at 61h, default E02Bh.
// - Read-only critical summary byte at 78h.
// - Read-only fault and warning summary word at 79h.
// - Read-only flag bytes at 7Ah, 7Bh and 7Dh.
// - Read-only communication flags 7Eh and vendor flags 80h.
// - Live telemetry reads at 8Bh, 8Ch and 8Eh.
// - Code 98h reads fixed 11h.
// - Scratch word at D0h, resets to zero, no side effect.
// - Trim at D4h offsets the reference, default zero.
// - Margin steps at D5h (001Eh) and D6h (FFE2h).
// - Power-good window select at D7h, default 00h.
// - On/off delay ratio at D8h, default 00h.
// - Options at E5h, default 0004h.
// - Alert source mask at E7h, default 0100h.
// - Code FCh reads 12-bit identifier and 4-bit revision.
// - Enable bit clear disables switching when ONOFF_PU and ONOFF_CMD are set; bits 5..2 select margin.
// - Enable needs input above lockout, gating config and no fault.
// - Margin codes 00XX off, 0101/0110 low, 1001/1010 high.
// - Enable bit honoured only when command gating is configured.
module pcb_cmd_bank
    import pcb_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1,
    parameter logic [11:0] PART_ID = PART_ID_DEF,
    parameter logic [3:0] PART_REV = PART_REV_DEF
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic LINK_CLK,
    input wire logic [7:0] LINK_CMD,
    input wire logic [15:0] LINK_WDATA,
    input wire logic LINK_WR,
    input wire logic LINK_RD,
    output logic LINK_BUSY,
    output logic LINK_DONE,
    output logic LINK_ERR,
    output logic [15:0] LINK_RDATA,
    input wire logic VIN_ABOVE_UVLO,
    input wire logic CONTROL_PIN,
    input wire logic FAULT_PRESENT,
    input wire logic ONOFF_PU,
    input wire logic ONOFF_CMD,
    input wire logic ONOFF_PIN,
    input wire logic ONOFF_POL,
    input wire logic [15:0] STATUS_SUMMARY,
    input wire logic [7:0] VOUT_FLAGS,
    input wire logic [7:0] IOUT_FLAGS,
    input wire logic [7:0] TEMP_FLAGS,
    input wire logic [7:0] COMM_FLAGS,
    input wire logic [7:0] VEND_FLAGS,
    input wire logic [15:0] MEAS_VOUT,
    input wire logic [15:0] MEAS_IOUT,
    input wire logic [15:0] MEAS_TEMP,
    output logic SWITCH_EN,
    output logic DRIVERS_OFF,
    output logic [1:0] MARGIN_STATE,
    output logic MARGIN_ACT_ON_FAULT,
    output logic [15:0] VREF_OFFSET,
    output logic [15:0] OC_FAULT_LEVEL,
    output logic [7:0] OC_FAULT_ACTION,
    output logic [15:0] OC_WARN_LEVEL,
    output logic [15:0] OT_FAULT_LEVEL,
    output logic [15:0] OT_WARN_LEVEL,
    output logic [15:0] RISE_TIME,
    output logic [7:0] PG_WINDOW,
    output logic [7:0] DELAY_RATIO,
    output logic [15:0] OPTIONS_OUT,
    output logic [15:0] ALERT_MASK
);
    localparam logic [15:0] RST_OC_FLT =
        LARGE_VARIANT ? RST_OC_FLT_L : RST_OC_FLT_S;
    localparam logic [15:0] RST_OC_WRN =
        LARGE_VARIANT ? RST_OC_WRN_L : RST_OC_WRN_S;

    // Link domain state
    logic lk_rstn;
    logic lk_busy_ff;
    logic lk_req_tog_ff;
    logic [7:0] lk_cmd_ff;
    logic [15:0] lk_wdata_ff;
    logic lk_wr_ff;
    logic lk_ack_s;
    logic lk_ack_d_ff;
    logic lk_done_ff;
    logic lk_err_ff;
    logic [15:0] lk_rdata_ff;
    // System domain state
    logic sy_req_s;
    logic sy_req_d_ff;
    logic ack_tog_ff;
    logic [15:0] acc_rdata_ff;
    logic acc_err_ff;
    logic [1:0] pin_s;
    logic sw_en_ff;
    pcb_margin_e margin_ff;
    logic act_ff;
    logic [15:0] vref_ff;
    logic [15:0] rd_word;
    logic rd_hit;
    logic rd_ro;
    logic [7:0] out_ctrl_q;
    logic [15:0] scratch_q;
    logic [15:0] trim_q;
    logic [15:0] mup_q;
    logic [15:0] mdn_q;

    // Link reset is RSTN brought onto the link clock
    pcb_sync #(.W(1)) u_lk_rst (.clk(LINK_CLK), .d(RSTN), .q(lk_rstn));
    pcb_sync #(.W(1)) u_lk_ack (.clk(LINK_CLK), .d(ack_tog_ff),
        .q(lk_ack_s));
    wire lk_start = (LINK_WR | LINK_RD) & ~lk_busy_ff;
    wire lk_ack_seen = lk_ack_s ^ lk_ack_d_ff;

    // Capture a request and hold it until the answer returns
    always_ff @(posedge LINK_CLK) begin
        if (!lk_rstn) begin
            lk_busy_ff <= 1'b0;
            lk_req_tog_ff <= 1'b0;
            lk_cmd_ff <= 8'h00;
            lk_wdata_ff <= 16'h0000;
            lk_wr_ff <= 1'b0;
        end else if (lk_start) begin
            lk_busy_ff <= 1'b1;
            lk_req_tog_ff <= ~lk_req_tog_ff;
            lk_cmd_ff <= LINK_CMD;
            lk_wdata_ff <= LINK_WDATA;
            lk_wr_ff <= LINK_WR;
        end else if (lk_ack_seen) begin
            lk_busy_ff <= 1'b0;
        end
    end

    // Return the answer in the link domain
    always_ff @(posedge LINK_CLK) begin
        if (!lk_rstn) begin
            lk_ack_d_ff <= 1'b0;
            lk_done_ff <= 1'b0;
            lk_err_ff <= 1'b0;
            lk_rdata_ff <= 16'h0000;
        end else begin
            lk_ack_d_ff <= lk_ack_s;
            lk_done_ff <= lk_ack_seen;
            if (lk_ack_seen) begin
                lk_err_ff <= acc_err_ff;
                lk_rdata_ff <= acc_rdata_ff;
            end
        end
    end
    assign LINK_BUSY = lk_busy_ff;
    assign LINK_DONE = lk_done_ff;
    assign LINK_ERR = lk_err_ff;
    assign LINK_RDATA = lk_rdata_ff;

    // Request toggle and pins enter the system domain
    pcb_sync #(.W(1)) u_sy_req (.clk(SYS_CLK), .d(lk_req_tog_ff),
        .q(sy_req_s));
    pcb_sync #(.W(2)) u_pins (.clk(SYS_CLK),
        .d({VIN_ABOVE_UVLO, CONTROL_PIN}), .q(pin_s));
    wire vin_ok = pin_s[1];
    wire ctrl_lvl = pin_s[0];
    wire acc_go = sy_req_s ^ sy_req_d_ff;
    wire wr_go = acc_go & lk_wr_ff;

    // Writable registers, each loads only on its own code
    pcb_rw_reg #(.W(8), .RST(RST_OUT_CTRL)) u_out_ctrl (.clk(SYS_CLK),
        .rst_n(RSTN), .wr_en(wr_go && lk_cmd_ff == CMD_OUT_CTRL),
        .wdata(lk_wdata_ff[7:0] & OUT_CTRL_WMASK), .q(out_ctrl_q));
    pcb_rw_reg #(.W(16), .RST(RST_OC_FLT)) u_oc_flt (.clk(SYS_CLK),
        .rst_n(RSTN), .wr_en(wr_go && lk_cmd_ff == CMD_OC_FLT),
        .wdata(lk_wdata_ff), .q(OC_FAULT_LEVEL));
    pcb_rw_reg #(.W(8), .RST(RST_OC_ACT)) u_oc_act (.clk(SYS_CLK),
        .rst_n(RSTN), .wr_en(wr_go && lk_cmd_ff == CMD_OC_ACT),
        .wdata(lk_wdata_ff[7:0]), .q(OC_FAULT_ACTION));
    pcb_rw_reg #(.W(16), .RST(RST_OC_WRN)) u_oc_wrn (.clk(SYS_CLK),
        .rst_n(RSTN), .wr_en(wr_go && lk_cmd_ff == CMD_OC_WRN),
        .wdata(lk_wdata_ff), .q(OC_WARN_LEVEL));
    pcb_rw_reg #(.W(16), .RST(RST_OT_FLT)) u_ot_flt (.clk(SYS_CLK),
        .rst_n(RSTN), .wr_en(wr_go && lk_cmd_ff == CMD_OT_FLT),
        .wdata(lk_wdata_ff), .q(OT_FAULT_LEVEL));
    pcb_rw_reg #(.W(16), .RST(RST_OT_WRN)) u_ot_wrn (.clk(SYS_CLK),
        .rst_n(RSTN), .wr_en(wr_go && lk_cmd_ff == CMD_OT_WRN),
        .wdata(lk_wdata_ff), .q(OT_WARN_LEVEL));
    pcb_rw_reg #(.W(16), .RST(RST_RISE)) u_rise (.clk(SYS_CLK),
        .rst_n(RSTN), .wr_en(wr_go && lk_cmd_ff == CMD_RISE),
        .wdata(lk_wdata_ff), .q(RISE_TIME));
    pcb_rw_reg #(.W(16), .RST(RST_SCRATCH)) u_scratch (.clk(SYS_CLK),
        .rst_n(RSTN), .wr_en(wr_go && lk_cmd_ff == CMD_SCRATCH),
        .wdata(lk_wdata_ff), .q(scratch_q));
    pcb_rw_reg #(.W(16), .RST(RST_TRIM)) u_trim (.clk(SYS_CLK),
        .rst_n(RSTN), .wr_en(wr_go && lk_cmd_ff == CMD_TRIM),
        .wdata(lk_wdata_ff), .q(trim_q));
    pcb_rw_reg #(.W(16), .RST(RST_MUP)) u_mup (.clk(SYS_CLK),
        .rst_n(RSTN), .wr_en(wr_go && lk_cmd_ff == CMD_MUP),
        .wdata(lk_wdata_ff), .q(mup_q));
    pcb_rw_reg #(.W(16), .RST(RST_MDN)) u_mdn (.clk(SYS_CLK),
        .rst_n(RSTN), .wr_en(wr_go && lk_cmd_ff == CMD_MDN),
        .wdata(lk_wdata_ff), .q(mdn_q));
    pcb_rw_reg #(.W(8), .RST(RST_PG_WIN)) u_pg_win (.clk(SYS_CLK),
        .rst_n(RSTN), .wr_en(wr_go && lk_cmd_ff == CMD_PG_WIN),
        .wdata(lk_wdata_ff[7:0]), .q(PG_WINDOW));
    pcb_rw_reg #(.W(8), .RST(RST_DLY)) u_dly (.clk(SYS_CLK),
        .rst_n(RSTN), .wr_en(wr_go && lk_cmd_ff == CMD_DLY_RATIO),
        .wdata(lk_wdata_ff[7:0]), .q(DELAY_RATIO));
    pcb_rw_reg #(.W(16), .RST(RST_OPTIONS)) u_options (.clk(SYS_CLK),
        .rst_n(RSTN), .wr_en(wr_go && lk_cmd_ff == CMD_OPTIONS),
        .wdata(lk_wdata_ff), .q(OPTIONS_OUT));
    pcb_rw_reg #(.W(16), .RST(RST_ALERT_MASK)) u_alert (.clk(SYS_CLK),
        .rst_n(RSTN), .wr_en(wr_go && lk_cmd_ff == CMD_ALERT_MASK),
        .wdata(lk_wdata_ff), .q(ALERT_MASK));

    // Read selection; rd_ro marks codes that refuse writes
    always_comb begin
        rd_word = 16'h0000;
        rd_hit = 1'b1;
        rd_ro = 1'b0;
        case (lk_cmd_ff)
            CMD_OUT_CTRL: rd_word = {8'h00, out_ctrl_q};
            CMD_OC_FLT: rd_word = OC_FAULT_LEVEL;
            CMD_OC_ACT: rd_word = {8'h00, OC_FAULT_ACTION};
            CMD_OC_WRN: rd_word = OC_WARN_LEVEL;
            CMD_OT_FLT: rd_word = OT_FAULT_LEVEL;
            CMD_OT_WRN: rd_word = OT_WARN_LEVEL;
            CMD_RISE: rd_word = RISE_TIME;
            CMD_CRIT_SUM: begin
                rd_word = {8'h00, STATUS_SUMMARY[7:0]};
                rd_ro = 1'b1;
            end
            CMD_FW_SUM: begin
                rd_word = STATUS_SUMMARY;
                rd_ro = 1'b1;
            end
            CMD_VOUT_FLG: begin
                rd_word = {8'h00, VOUT_FLAGS};
                rd_ro = 1'b1;
            end
            CMD_IOUT_FLG: begin
                rd_word = {8'h00, IOUT_FLAGS};
                rd_ro = 1'b1;
            end
            CMD_TEMP_FLG: begin
                rd_word = {8'h00, TEMP_FLAGS};
                rd_ro = 1'b1;
            end
            CMD_COMM_FLG: begin
                rd_word = {8'h00, COMM_FLAGS};
                rd_ro = 1'b1;
            end
            CMD_VEND_FLG: begin
                rd_word = {8'h00, VEND_FLAGS};
                rd_ro = 1'b1;
            end
            CMD_MEAS_V: begin
                rd_word = MEAS_VOUT;
                rd_ro = 1'b1;
            end
            CMD_MEAS_I: begin
                rd_word = MEAS_IOUT;
                rd_ro = 1'b1;
            end
            CMD_MEAS_T: begin
                rd_word = MEAS_TEMP;
                rd_ro = 1'b1;
            end
            CMD_PROTO_REV: begin
                rd_word = {8'h00, PROTO_REV_VAL};
                rd_ro = 1'b1;
            end
            CMD_PART_ID: begin
                rd_word = {PART_ID, PART_REV};
                rd_ro = 1'b1;
            end
            CMD_SCRATCH: rd_word = scratch_q;
            CMD_TRIM: rd_word = trim_q;
            CMD_MUP: rd_word = mup_q;
            CMD_MDN: rd_word = mdn_q;
            CMD_PG_WIN: rd_word = {8'h00, PG_WINDOW};
            CMD_DLY_RATIO: rd_word = {8'h00, DELAY_RATIO};
            CMD_OPTIONS: rd_word = OPTIONS_OUT;
            CMD_ALERT_MASK: rd_word = ALERT_MASK;
            default: rd_hit = 1'b0;
        endcase
    end

    // Answer each access once and toggle the acknowledge
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            sy_req_d_ff <= 1'b0;
            ack_tog_ff <= 1'b0;
            acc_rdata_ff <= 16'h0000;
            acc_err_ff <= 1'b0;
        end else begin
            sy_req_d_ff <= sy_req_s;
            if (acc_go) begin
                ack_tog_ff <= ~ack_tog_ff;
                acc_rdata_ff <= lk_wr_ff ? 16'h0000 : rd_word;
                acc_err_ff <= ~rd_hit | (lk_wr_ff & rd_ro);
            end
        end
    end

    // Switching enable from enable bit, gating config, lockout, fault
    wire on_bit = out_ctrl_q[ON_BIT];
    wire cmd_ok = ~ONOFF_CMD | on_bit;
    wire pin_ok = ~ONOFF_PIN | (ctrl_lvl == ONOFF_POL);
    wire gate_ok = ~ONOFF_PU | (cmd_ok & pin_ok);
    wire nxt_sw_en = vin_ok & ~FAULT_PRESENT & gate_ok;

    // Margin decode; unlisted codes fall back to off
    wire [3:0] mcode = out_ctrl_q[MARGIN_MSB:MARGIN_LSB];
    wire m_low = (mcode == MRG_LOW_IGN) | (mcode == MRG_LOW_ACT);
    wire m_high = (mcode == MRG_HIGH_IGN) | (mcode == MRG_HIGH_ACT);
    wire m_act = (mcode == MRG_LOW_ACT) | (mcode == MRG_HIGH_ACT);
    wire [15:0] step = m_low ? mdn_q : (m_high ? mup_q : 16'h0000);
    wire [15:0] nxt_vref = 16'(trim_q + step);

    // Applied control outputs
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            sw_en_ff <= 1'b0;
            margin_ff <= MRG_OFF;
            act_ff <= 1'b0;
            vref_ff <= RST_TRIM;
        end else begin
            sw_en_ff <= nxt_sw_en;
            margin_ff <= m_low ? MRG_LOW : (m_high ? MRG_HIGH : MRG_OFF);
            act_ff <= m_act;
            vref_ff <= nxt_vref;
        end
    end
    assign SWITCH_EN = sw_en_ff;
    assign DRIVERS_OFF = ~sw_en_ff;
    assign MARGIN_STATE = margin_ff;
    assign MARGIN_ACT_ON_FAULT = act_ff;
    assign VREF_OFFSET = vref_ff;

    // Checks on the system domain
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    property p_on_clear_off;
        ONOFF_PU && ONOFF_CMD && !on_bit |=> !SWITCH_EN && DRIVERS_OFF;
    endproperty
    a_on_clear_off: assert property (p_on_clear_off)
        else $error("switching with enable bit clear");

    property p_cmd_ignored;
        ONOFF_PU && !ONOFF_CMD && !ONOFF_PIN && vin_ok && !FAULT_PRESENT
            |=> SWITCH_EN;
    endproperty
    a_cmd_ignored: assert property (p_cmd_ignored)
        else $error("enable bit not ignored");

    property p_block_off;
        FAULT_PRESENT || !vin_ok |=> !SWITCH_EN;
    endproperty
    a_block_off: assert property (p_block_off)
        else $error("switching during fault or lockout");

    sequence s_scratch_wr;
        wr_go && lk_cmd_ff == CMD_SCRATCH;
    endsequence
    property p_scratch;
        s_scratch_wr |=> scratch_q == $past(lk_wdata_ff);
    endproperty
    a_scratch: assert property (p_scratch)
        else $error("scratch write lost");

    property p_ro_write;
        wr_go && rd_ro |=> $stable(out_ctrl_q) && $stable(trim_q)
            && $stable(scratch_q) && acc_err_ff;
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("read-only write had effect");

    property p_rev;
        acc_go && !lk_wr_ff && lk_cmd_ff == CMD_PROTO_REV
            |=> acc_rdata_ff == {8'h00, PROTO_REV_VAL};
    endproperty
    a_rev: assert property (p_rev)
        else $error("wrong protocol revision");

    property p_margin_low;
        mcode == MRG_LOW_IGN |=> VREF_OFFSET == 16'($past(trim_q)
            + $past(mdn_q)) && MARGIN_STATE == MRG_LOW;
    endproperty
    a_margin_low: assert property (p_margin_low)
        else $error("low margin not applied");

    sequence s_rst_rel;
        $rose(RSTN);
    endsequence
    property p_defaults;
        s_rst_rel |-> OC_FAULT_LEVEL == RST_OC_FLT && trim_q == RST_TRIM
            && mup_q == RST_MUP && mdn_q == RST_MDN
            && ALERT_MASK == RST_ALERT_MASK;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("wrong reset default");

    property p_rsvd;
        ##1 out_ctrl_q[6] == 1'b0 && out_ctrl_q[1:0] == 2'b00;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved control bit set");
endmodule // pcb_cmd_bank

/* File: core/pcb_pkg.sv */
// Purpose: Shared constants for the command register bank
// Assumes: Command codes are one byte; data words are two bytes
// Notes: Byte-wide registers sit in the low byte of a word
package pcb_pkg;
    // Command codes
    localparam logic [7:0] CMD_OUT_CTRL = 8'h01;
    localparam logic [7:0] CMD_OC_FLT = 8'h46;
    localparam logic [7:0] CMD_OC_ACT = 8'h47;
    localparam logic [7:0] CMD_OC_WRN = 8'h4A;
    localparam logic [7:0] CMD_OT_FLT = 8'h4F;
    localparam logic [7:0] CMD_OT_WRN = 8'h51;
    localparam logic [7:0] CMD_RISE = 8'h61;
    localparam logic [7:0] CMD_CRIT_SUM = 8'h78;
    localparam logic [7:0] CMD_FW_SUM = 8'h79;
    localparam logic [7:0] CMD_VOUT_FLG = 8'h7A;
    localparam logic [7:0] CMD_IOUT_FLG = 8'h7B;
    localparam logic [7:0] CMD_TEMP_FLG = 8'h7D;
    localparam logic [7:0] CMD_COMM_FLG = 8'h7E;
    localparam logic [7:0] CMD_VEND_FLG = 8'h80;
    localparam logic [7:0] CMD_MEAS_V = 8'h8B;
    localparam logic [7:0] CMD_MEAS_I = 8'h8C;
    localparam logic [7:0] CMD_MEAS_T = 8'h8E;
    localparam logic [7:0] CMD_PROTO_REV = 8'h98;
    localparam logic [7:0] CMD_SCRATCH = 8'hD0;
    localparam logic [7:0] CMD_TRIM = 8'hD4;
    localparam logic [7:0] CMD_MUP = 8'hD5;
    localparam logic [7:0] CMD_MDN = 8'hD6;
    localparam logic [7:0] CMD_PG_WIN = 8'hD7;
    localparam logic [7:0] CMD_DLY_RATIO = 8'hD8;
    localparam logic [7:0] CMD_OPTIONS = 8'hE5;
    localparam logic [7:0] CMD_ALERT_MASK = 8'hE7;
    localparam logic [7:0] CMD_PART_ID = 8'hFC;
    // Reset values
    localparam logic [15:0] RST_OUT_CTRL = 16'h0000;
    localparam logic [15:0] RST_OC_FLT_L = 16'hF84E;
    localparam logic [15:0] RST_OC_FLT_S = 16'hF834;
    localparam logic [15:0] RST_OC_ACT = 16'h0007;
    localparam logic [15:0] RST_OC_WRN_L = 16'hF8C3;
    localparam logic [15:0] RST_OC_WRN_S = 16'hF828;
    localparam logic [15:0] RST_OT_FLT = 16'h0096;
    localparam logic [15:0] RST_OT_WRN = 16'h007D;
    localparam logic [15:0] RST_RISE = 16'hE02B;
    localparam logic [15:0] RST_SCRATCH = 16'h0000;
    localparam logic [15:0] RST_TRIM = 16'h0000;
    localparam logic [15:0] RST_MUP = 16'h001E;
    localparam logic [15:0] RST_MDN = 16'hFFE2;
    localparam logic [15:0] RST_PG_WIN = 16'h0000;
    localparam logic [15:0] RST_DLY = 16'h0000;
    localparam logic [15:0] RST_OPTIONS = 16'h0004;
    localparam logic [15:0] RST_ALERT_MASK = 16'h0100;
    localparam logic [7:0] PROTO_REV_VAL = 8'h11;
    // Identity defaults, values arbitrary
    localparam logic [11:0] PART_ID_DEF = 12'h5A5;
    localparam logic [3:0] PART_REV_DEF = 4'h1;
    // Output control fields
    localparam logic [7:0] OUT_CTRL_WMASK = 8'hBC;
    localparam int ON_BIT = 7;
    localparam int MARGIN_MSB = 5;
    localparam int MARGIN_LSB = 2;
    localparam logic [3:0] MRG_LOW_IGN = 4'h5;
    localparam logic [3:0] MRG_LOW_ACT = 4'h6;
    localparam logic [3:0] MRG_HIGH_IGN = 4'h9;
    localparam logic [3:0] MRG_HIGH_ACT = 4'hA;
    // Applied margin state
    typedef enum logic [1:0] {
        MRG_OFF = 2'b00,
        MRG_LOW = 2'b01,
        MRG_HIGH = 2'b10
    } pcb_margin_e;
endpackage

/* File: core/pcb_rw_reg.sv */
// Purpose: One writable register with a reset value
// Assumes: Synchronous active-low reset
// Notes: Width sets how many low bits of RST are used
module pcb_rw_reg #(
    parameter int W = 16,
    parameter logic [15:0] RST = 16'h0000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] q
);
    logic [W-1:0] q_ff;

    // Load on write, reset to constant
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_ff <= RST[W-1:0];
        end else if (wr_en) begin
            q_ff <= wdata;
        end
    end
    assign q = q_ff;
endmodule // pcb_rw_reg

/* File: core/pcb_sync.sv */
// Purpose: Two-stage synchroniser for levels and toggles
// Assumes: Each bit crosses independently
// Notes: Only the second stage may be read by other logic
module pcb_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;

    // Two flops in the destination domain
    always_ff @(posedge clk) begin
        s1_ff <= d;
        s2_ff <= s1_ff;
    end
    assign q = s2_ff;
endmodule // pcb_sync

/* File: sim/pcb_link_host.sv */
// Purpose: Link-side host issuing one command at a time
// Assumes: A request is taken on the LINK_CLK edge where it is high
// Notes: Released cmd and wdata show inverted values; wr and rd drop to zero
module pcb_link_host (
    input wire logic clk,
    input wire logic done,
    input wire logic err,
    input wire logic [15:0] rdata,
    output logic [7:0] cmd,
    output logic [15:0] wdata,
    output logic wr,
    output logic rd
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle lines at time zero
    initial begin
        cmd = 8'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
    end
    // One access with a bounded wait for the answer
    task automatic xfer(input logic [7:0] c, input logic [15:0] d,
        input logic w, output logic [15:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        cmd <= c;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        cmd <= ~c;
        wdata <= ~d;
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        while (done !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        q = (n < 20) ? rdata : 16'hXXXX; // Unknown marks a lost read
        e = (n < 20) ? err : 1'bx; // Unknown marks a lost answer
    endtask
endmodule // pcb_link_host

/* File: sim/pmbus_command_register_bank_bench.sv */
// Purpose: Self-checking bench for the command register bank
// Assumes: Large variant defaults; every on/off config bit is driven
// Notes: Random data from a fixed seed, all margin codes by loop
module pmbus_command_register_bank_bench;
    import pcb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, link_clk = 1'b0, rstn = 1'b0, vin = 1'b0;
    logic cpin = 1'b0, fault = 1'b0, pu = 1'b1, ocmd = 1'b0, opol = 1'b0;
    logic wr, rd, done, err, sw, doff, act, e, cpr = 1'b0;
    logic [7:0] pb [3];
    logic [15:0] pw [7];
    logic [1:0] mst;
    logic [7:0] cmd, vf = 8'h00, iof = 8'h00, tf = 8'h00;
    logic [7:0] cf = 8'h00, nf = 8'h00;
    logic [15:0] wdata, rdata, vref, q, summ = 16'h0000;
    logic [15:0] mv = 16'h0000, mi = 16'h0000, mt = 16'h0000;
    int n_mismatch = 0, samples_checked = 0, cyc = 0;
    logic [7:0] rw_c [14] = '{CMD_OC_FLT, CMD_OC_ACT, CMD_OC_WRN,
        CMD_OT_FLT, CMD_OT_WRN, CMD_RISE, CMD_SCRATCH, CMD_TRIM, CMD_MUP,
        CMD_MDN, CMD_PG_WIN, CMD_DLY_RATIO, CMD_OPTIONS, CMD_ALERT_MASK};
    logic [15:0] rw_d [14] = '{RST_OC_FLT_L, RST_OC_ACT, RST_OC_WRN_L,
        RST_OT_FLT, RST_OT_WRN, RST_RISE, RST_SCRATCH, RST_TRIM, RST_MUP,
        RST_MDN, RST_PG_WIN, RST_DLY, RST_OPTIONS, RST_ALERT_MASK};
    logic [7:0] ro_c [12] = '{CMD_CRIT_SUM, CMD_FW_SUM, CMD_VOUT_FLG,
        CMD_IOUT_FLG, CMD_TEMP_FLG, CMD_COMM_FLG, CMD_VEND_FLG, CMD_MEAS_V,
        CMD_MEAS_I, CMD_MEAS_T, CMD_PROTO_REV, CMD_PART_ID};
    pcb_cmd_bank i_dut (.SYS_CLK(sys_clk), .RSTN(rstn), .LINK_CLK(link_clk),
        .LINK_CMD(cmd), .LINK_WDATA(wdata), .LINK_WR(wr), .LINK_RD(rd),
        .LINK_BUSY(), .LINK_DONE(done), .LINK_ERR(err), .LINK_RDATA(rdata),
        .VIN_ABOVE_UVLO(vin), .CONTROL_PIN(cpin), .FAULT_PRESENT(fault),
        .ONOFF_PU(pu), .ONOFF_CMD(ocmd), .ONOFF_PIN(cpr), .ONOFF_POL(opol),
        .STATUS_SUMMARY(summ), .VOUT_FLAGS(vf), .IOUT_FLAGS(iof),
        .TEMP_FLAGS(tf), .COMM_FLAGS(cf), .VEND_FLAGS(nf), .MEAS_VOUT(mv),
        .MEAS_IOUT(mi), .MEAS_TEMP(mt), .SWITCH_EN(sw), .DRIVERS_OFF(doff),
        .MARGIN_STATE(mst), .MARGIN_ACT_ON_FAULT(act), .VREF_OFFSET(vref),
        .OC_FAULT_LEVEL(pw[0]), .OC_FAULT_ACTION(pb[0]),
        .OC_WARN_LEVEL(pw[1]), .OT_FAULT_LEVEL(pw[2]), .OT_WARN_LEVEL(pw[3]),
        .RISE_TIME(pw[4]), .PG_WINDOW(pb[1]), .DELAY_RATIO(pb[2]),
        .OPTIONS_OUT(pw[5]), .ALERT_MASK(pw[6]));
    pcb_link_host i_host (.clk(link_clk), .done(done), .err(err),
        .rdata(rdata), .cmd(cmd), .wdata(wdata), .wr(wr), .rd(rd));
    // System clock and an unrelated link clock
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    // Comparison and closing report
    task automatic check(input string nm, input logic [15:0] x,
        input logic [15:0] y);
        samples_checked++;
        if (y !== x) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, x, y);
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic acc(input logic [7:0] c, input logic [15:0] d,
        input logic w);
        i_host.xfer(c, d, w, q, e);
    endtask
    // Expected live read values, byte sources zero-extended
    function automatic logic [15:0] ro_exp(input int i);
        logic [15:0] t [12];
        t = '{16'(summ[7:0]), summ, 16'(vf), 16'(iof), 16'(tf), 16'(cf),
            16'(nf), mv, mi, mt, 16'h0011, {PART_ID_DEF, PART_REV_DEF}};
        return t[i];
    endfunction
    // Register contents as seen on the output ports
    function automatic logic [15:0] port_val(input int i);
        logic [15:0] t [14];
        t = '{pw[0], 16'(pb[0]), pw[1], pw[2], pw[3], pw[4], 16'h0000,
            16'h0000, 16'h0000, 16'h0000, 16'(pb[1]), 16'(pb[2]), pw[5],
            pw[6]};
        return t[i];
    endfunction
    // Main sequence
    initial begin
        int i;
        logic [15:0] d, t, u, s;
        logic [3:0] m;
        logic [1:0] ms;
        void'($urandom(10));
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge link_clk);
        for (i = 0; i < 14; i++) begin
            acc(rw_c[i], 16'h0000, 1'b0);
            check("default", rw_d[i], q);
            d = 16'($urandom);
            acc(rw_c[i], d, 1'b1);
            acc(rw_c[i], 16'h0000, 1'b0);
            if (i == 1 || i == 10 || i == 11) d[15:8] = 8'h00;
            check("readback", d, q);
            if (i < 6 || i > 9) begin
                check("port", d, port_val(i));
            end
        end
        $display("test registers done");
        @(posedge sys_clk);
        {summ, mv, mi, mt, vf, iof, tf, cf, nf} <= 104'({$urandom,
            $urandom, $urandom, $urandom});
        for (i = 0; i < 12; i++) begin
            acc(ro_c[i], 16'($urandom), 1'b1);
            check("ro write err", 16'h0001, 16'(e));
            acc(ro_c[i], 16'h0000, 1'b0);
            check("ro read", ro_exp(i), q);
        end
        acc(8'h02, 16'h0000, 1'b0);
        check("unknown err", 16'h0001, 16'(e));
        $display("test read-only done");
        t = 16'($urandom);
        u = 16'($urandom);
        s = 16'($urandom);
        acc(CMD_TRIM, t, 1'b1);
        acc(CMD_MUP, u, 1'b1);
        acc(CMD_MDN, s, 1'b1);
        for (i = 0; i < 16; i++) begin
            m = i[3:0];
            ms = (m == 4'h5 || m == 4'h6) ? MRG_LOW :
                (m == 4'h9 || m == 4'hA) ? MRG_HIGH : MRG_OFF;
            acc(CMD_OUT_CTRL, {8'h00, 2'b11, m, 2'b11}, 1'b1);
            acc(CMD_OUT_CTRL, 16'h0000, 1'b0);
            check("ctrl read", {8'h00, 2'b10, m, 2'b00}, q);
            repeat (6) @(posedge sys_clk);
            check("margin", 16'(ms), 16'(mst));
            check("act", 16'(m == 4'h6 || m == 4'hA), 16'(act));
            d = (ms == MRG_LOW) ? s : (ms == MRG_HIGH) ? u : 16'h0000;
            check("vref", t + d, vref);
        end
        $display("test margin done");
        for (i = 0; i < 24; i++) begin
            d = 16'($urandom);
            if (i < 2) d[7:4] = {1'b1, i[0], 2'b10};
            if (i < 2) d[1] = 1'b0;
            acc(CMD_OUT_CTRL, {8'h00, d[0], 7'h00}, 1'b1);
            @(posedge sys_clk);
            {pu, ocmd, vin, fault, cpin, opol, cpr} <= d[7:1];
            repeat (8) @(posedge sys_clk);
            s[0] = vin & !fault & (!pu | ((!ocmd | d[0])
                & (!cpr | (cpin == opol))));
            check("switch", 16'(s[0]), 16'(sw));
            check("drivers off", 16'(!s[0]), 16'(doff));
        end
        $display("test enable done");
        end_of_test();
    end
endmodule // pmbus_command_register_bank_bench
